/* File: pkg/ssp_pkg.sv */
//
// Behaviour
// (RULE_01) Three-bit mode field in mode control selects SPI or I2C personality.
// (RULE_02) SPI uses data in, data out, serial clock and active-low select.
// (RULE_03) The master starts every transfer and alone drives the serial clock.
// (RULE_04) Only one select pin; extra slaves need general-purpose pins.
// (RULE_05) Select enable 1 makes select pin functional; 0 leaves it floating.
// (RULE_06) Module on bit works only when the pin option assigns the pins.
// (RULE_07) Static options decide whether select enable and collision bit function.
// (RULE_08) One 8-bit data register holds both sent and received byte.
// (RULE_09) Software loads byte before transfer and reads result after it.
// (RULE_10) Full duplex: one bit out and one bit in per clock.
// (RULE_11) Software selects LSB-first or MSB-first shift order.
// (RULE_12) Software selects rising or falling capture edge.
// (RULE_13) Mode control holds enable, clock rate, peripheral clock enable and divider.
// (RULE_14) Each transfer moves exactly eight bits, then stops.
// (RULE_15) Modes 000-010 master /4,/16,/64; 011 sub; 100 timer/2; 101 slave; 110 I2C.
// (RULE_16) Master data write starts transfer; completion sets sticky complete flag.
// (RULE_17) Data write during transfer is discarded and sets collision flag.
// (RULE_18) Polarity 0 idles clock high, 1 idles low; edge bit picks capture edge.
package ssp_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] SSP_ADDR_MODE   = 8'h00;
    localparam logic [7:0] SSP_ADDR_DATA   = 8'h04;
    localparam logic [7:0] SSP_ADDR_FORMAT = 8'h08;
    localparam logic [7:0] SSP_ADDR_STATUS = 8'h0C;
    localparam logic [7:0] SSP_ADDR_MASK   = 8'h10;
    localparam int         SSP_ADDR_W      = 8;
    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int MODE_SEL_HI   = 7;
    localparam int MODE_SEL_LO   = 5;
    localparam int MODE_PCK_EN   = 4;
    localparam int MODE_PCK_HI   = 3;
    localparam int MODE_PCK_LO   = 2;
    localparam int MODE_ON       = 1;
    localparam int FMT_POL       = 5;
    localparam int FMT_EDGE      = 4;
    localparam int FMT_MSB       = 3;
    localparam int FMT_SELECT_PIN_ENABLE      = 2;
    localparam int FMT_WRITE_COLLISION_FLAG      = 1;
    localparam int FMT_TRF       = 0;
    localparam int IRQ_W         = 2;
    localparam logic [7:0] MODE_RESET = 8'hE0;
    localparam logic [7:0] MODE_WMASK = 8'hFE;
    localparam logic [7:0] FMT_RESET  = 8'h00;
    // ----------------------------------------------------------------
    // mode field encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SSP_M_DIV4  = 3'b000,
        SSP_M_DIV16 = 3'b001,
        SSP_M_DIV64 = 3'b010,
        SSP_M_SUB   = 3'b011,
        SSP_M_TMR   = 3'b100,
        SSP_M_SLAVE = 3'b101,
        SSP_M_I2C   = 3'b110,
        SSP_M_NONE  = 3'b111
    } ssp_mode_type;
    typedef enum logic [1:0] {
        SSP_IDLE  = 2'b00,
        SSP_LEAD  = 2'b01,
        SSP_TRAIL = 2'b10
    } ssp_state_type;
    localparam int SSP_DIV4_HALF  = 2;
    localparam int SSP_DIV16_HALF = 8;
    localparam int SSP_DIV64_HALF = 32;
    localparam logic [2:0] SSP_BITS_LAST = 3'h7;
    localparam logic [5:0] SSP_CNT_ONE   = 6'h01;
endpackage

/* File: verilog/ssp_spi_port.sv */
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
module ssp_spi_port import ssp_pkg::*; (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        opt_pins_enable,
    input  wire logic        opt_select_pin_enable_enable,
    input  wire logic        opt_write_collision_flag_enable,
    input  wire logic        sub_clk_tick,
    input  wire logic        timer_tone_output,
    input  wire logic        sdi_in,
    output logic             sdo_out,
    output logic             sdo_oe,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    input  wire logic        slave_select_n_in,
    output logic             slave_select_n_out,
    output logic             slave_select_n_oe,
    output logic             irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                ap_wr;
        logic                ap_rd;
        logic [SSP_ADDR_W-1:0] ap_addr;
        logic [31:0]         rdata;
        logic [7:0]          mode;
        logic [7:0]          fmt;
        logic [7:0]          shift;
        logic [IRQ_W-1:0]    mask;
        ssp_state_type       st;
        logic [2:0]          bits;
        logic [5:0]          cnt;
        logic                sck;
        logic                sdo;
        logic                sin;
        logic [2:0]          sck_s;
        logic [2:0]          sdi_s;
        logic [2:0]          ss_s;
        logic [2:0]          sub_s;
        logic [2:0]          tmr_s;
        logic                tmr_half;
        logic                frame;
    } ssp_regs_type;

    ssp_regs_type r_reg, r_next;

    logic         on;
    logic         active;
    logic         is_master;
    logic         tick;
    logic [5:0]   half;
    logic         capture;
    logic         launch;
    logic         ssck_rise;
    logic         ssck_fall;
    logic         ss_low;
    logic         data_wr;
    ssp_mode_type mode_f;

    assign mode_f    = ssp_mode_type'(r_reg.mode[MODE_SEL_HI:MODE_SEL_LO]);
    assign on        = r_reg.mode[MODE_ON] & opt_pins_enable;                  // [RULE_06]
    assign is_master = on && (mode_f <= SSP_M_TMR);                            // [RULE_15]
    assign active    = (r_reg.st != SSP_IDLE);
    assign ssck_rise = (r_reg.sck_s[1] == r_reg.sck_s[2]) ? 1'b0 : r_reg.sck_s[1];
    assign ssck_fall = (r_reg.sck_s[1] != r_reg.sck_s[2]) & ~r_reg.sck_s[1];
    assign ss_low    = ~(r_reg.ss_s[1] & r_reg.ss_s[2]) & ~(r_reg.ss_s[1] | r_reg.ss_s[2]);
    assign data_wr   = r_reg.ap_wr && (r_reg.ap_addr == SSP_ADDR_DATA);

    always_comb begin
        unique case (mode_f)
            SSP_M_DIV4:  half = 6'(SSP_DIV4_HALF);
            SSP_M_DIV16: half = 6'(SSP_DIV16_HALF);
            default:     half = 6'(SSP_DIV64_HALF);
        endcase
    end

    always_comb begin
        tick = 1'b0;
        unique case (mode_f)
            SSP_M_SUB:  tick = r_reg.sub_s[1] & ~r_reg.sub_s[2];
            SSP_M_TMR:  tick = r_reg.tmr_s[1] & ~r_reg.tmr_s[2] & r_reg.tmr_half;
            default:    tick = (r_reg.cnt == SSP_CNT_ONE);
        endcase
    end

    // slave-mode edges: capture edge per polarity/edge bits
    always_comb begin
        // pol 0 idle high: edge 0 capture rising; pol 1 idle low: edge 0 capture falling
        if (r_reg.fmt[FMT_POL] ^ r_reg.fmt[FMT_EDGE]) begin                    // [RULE_18] [RULE_12]
            capture = ssck_fall;
            launch  = ssck_rise;
        end else begin
            capture = ssck_rise;
            launch  = ssck_fall;
        end
    end

    always_comb begin
        r_next = r_reg;
        // ------------------------------------------------------------
        // synchronisers
        // ------------------------------------------------------------
        r_next.sck_s = {r_reg.sck_s[1:0], sck_in};
        r_next.sdi_s = {r_reg.sdi_s[1:0], sdi_in};
        r_next.ss_s  = {r_reg.ss_s[1:0], slave_select_n_in};
        r_next.sub_s = {r_reg.sub_s[1:0], sub_clk_tick};
        r_next.tmr_s = {r_reg.tmr_s[1:0], timer_tone_output};
        if (r_reg.tmr_s[1] & ~r_reg.tmr_s[2])
            r_next.tmr_half = ~r_reg.tmr_half;
        // ------------------------------------------------------------
        // bus address phase
        // ------------------------------------------------------------
        r_next.ap_wr   = hsel & hready & htrans[1] & hwrite;
        r_next.ap_rd   = hsel & hready & htrans[1] & ~hwrite;
        r_next.ap_addr = haddr[SSP_ADDR_W-1:0];
        r_next.rdata   = '0;
        if (hsel & hready & htrans[1] & ~hwrite) begin
            unique case (haddr[SSP_ADDR_W-1:0])
                SSP_ADDR_MODE:   r_next.rdata = {24'h0, r_reg.mode};
                SSP_ADDR_DATA:   r_next.rdata = {24'h0, r_reg.shift};          // [RULE_08]
                SSP_ADDR_FORMAT: r_next.rdata = {24'h0, r_reg.fmt};
                SSP_ADDR_STATUS: r_next.rdata = {30'h0, r_reg.fmt[FMT_WRITE_COLLISION_FLAG], r_reg.fmt[FMT_TRF]};
                SSP_ADDR_MASK:   r_next.rdata = {30'h0, r_reg.mask};
                default:         r_next.rdata = '0;
            endcase
        end
        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (r_reg.ap_wr) begin
            unique case (r_reg.ap_addr)
                SSP_ADDR_MODE:   r_next.mode = hwdata[7:0] & MODE_WMASK;       // [RULE_01] [RULE_13]
                SSP_ADDR_FORMAT: r_next.fmt  = hwdata[7:0];
                SSP_ADDR_STATUS: begin
                    if (hwdata[FMT_TRF])  r_next.fmt[FMT_TRF]  = 1'b0;
                    if (hwdata[FMT_WRITE_COLLISION_FLAG]) r_next.fmt[FMT_WRITE_COLLISION_FLAG] = 1'b0;
                end
                SSP_ADDR_MASK:   r_next.mask = hwdata[IRQ_W-1:0];
                default:         ;
            endcase
        end
        if (data_wr) begin
            if (active) begin
                if (opt_write_collision_flag_enable)
                    r_next.fmt[FMT_WRITE_COLLISION_FLAG] = 1'b1;                               // [RULE_17] [RULE_07]
            end else begin
                r_next.shift = hwdata[7:0];                                    // [RULE_09]
                r_next.sdo   = r_reg.fmt[FMT_MSB] ? hwdata[7] : hwdata[0];     // [RULE_11]
                if (is_master) begin                                           // [RULE_16] [RULE_03]
                    r_next.st   = SSP_LEAD;
                    r_next.bits = '0;
                    r_next.cnt  = half;
                end
            end
        end
        // ------------------------------------------------------------
        // shifter
        // ------------------------------------------------------------
        // select stays low one cycle past the last toggle so the far side sees it
        r_next.frame = active;
        if (!on) begin
            r_next.st  = SSP_IDLE;
            r_next.sck = ~r_reg.fmt[FMT_POL];
        end else if (is_master) begin
            if (r_reg.cnt != '0)
                r_next.cnt = r_reg.cnt - SSP_CNT_ONE;
            if (r_reg.st == SSP_IDLE)
                r_next.sck = ~r_reg.fmt[FMT_POL];                              // [RULE_18]
            if (active && tick) begin
                r_next.cnt = half;
                r_next.sck = ~r_reg.sck;
                if (r_reg.st == SSP_LEAD) begin
                    r_next.st = SSP_TRAIL;
                    if (r_reg.fmt[FMT_EDGE]) begin
                        // edge 1: the leading toggle is the capture edge
                        r_next.sin = sdi_in;                                   // [RULE_10] [RULE_12]
                    end else if (r_reg.bits != '0) begin
                        // edge 0: leading toggle launches; first bit already stands
                        r_next.shift = r_reg.fmt[FMT_MSB] ? {r_reg.shift[6:0], r_reg.sin}
                                                          : {r_reg.sin, r_reg.shift[7:1]};
                        r_next.sdo   = r_reg.fmt[FMT_MSB] ? r_reg.shift[6] : r_reg.shift[1];
                    end
                end else begin
                    r_next.bits = r_reg.bits + 3'h1;
                    r_next.st   = SSP_LEAD;
                    if (r_reg.fmt[FMT_EDGE]) begin
                        r_next.shift = r_reg.fmt[FMT_MSB] ? {r_reg.shift[6:0], r_reg.sin}
                                                          : {r_reg.sin, r_reg.shift[7:1]};
                        r_next.sdo   = r_reg.fmt[FMT_MSB] ? r_reg.shift[6] : r_reg.shift[1];
                    end else begin
                        r_next.sin = sdi_in;                                   // [RULE_12]
                    end
                    if (r_reg.bits == SSP_BITS_LAST) begin                     // [RULE_14]
                        r_next.st = SSP_IDLE;
                        r_next.fmt[FMT_TRF] = 1'b1;                            // [RULE_16]
                        // with edge 0 the data line is left alone: the far side samples it on this toggle
                        if (!r_reg.fmt[FMT_EDGE])
                            r_next.shift = r_reg.fmt[FMT_MSB] ? {r_reg.shift[6:0], sdi_in}
                                                              : {sdi_in, r_reg.shift[7:1]};
                    end
                end
            end
        end else if (mode_f == SSP_M_SLAVE) begin
            if (r_reg.fmt[FMT_SELECT_PIN_ENABLE] & opt_select_pin_enable_enable & ~ss_low) begin         // [RULE_05]
                r_next.st   = SSP_IDLE;
                r_next.bits = '0;
            end else if (capture) begin
                r_next.shift = r_reg.fmt[FMT_MSB] ? {r_reg.shift[6:0], r_reg.sdi_s[2]}
                                                  : {r_reg.sdi_s[2], r_reg.shift[7:1]};
                r_next.bits  = r_reg.bits + 3'h1;
                r_next.st    = SSP_TRAIL;
                if (r_reg.bits == SSP_BITS_LAST) begin                         // [RULE_14]
                    r_next.st = SSP_IDLE;
                    r_next.fmt[FMT_TRF] = 1'b1;
                end
            end else if (launch && active) begin
                r_next.sdo = r_reg.fmt[FMT_MSB] ? r_reg.shift[7] : r_reg.shift[0];
            end
        end
        if (!opt_write_collision_flag_enable)
            r_next.fmt[FMT_WRITE_COLLISION_FLAG] = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg          <= '0;
            r_reg.mode     <= MODE_RESET;
            r_reg.fmt      <= FMT_RESET;
            r_reg.sck      <= 1'b1;
            r_reg.sck_s    <= 3'h7;
            r_reg.ss_s     <= 3'h7;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata             = r_reg.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign sdo_out            = r_reg.sdo;                                     // [RULE_02]
    assign sdo_oe             = on && (mode_f <= SSP_M_SLAVE);
    assign sck_out            = r_reg.sck;
    assign sck_oe             = is_master;                                     // [RULE_03]
    // one select only; further slaves need general-purpose pins
    assign slave_select_n_out = ~(active | r_reg.frame);                       // [RULE_04]
    assign slave_select_n_oe  = is_master & r_reg.fmt[FMT_SELECT_PIN_ENABLE] & opt_select_pin_enable_enable; // [RULE_05] [RULE_07]
    assign irq                = |({r_reg.fmt[FMT_WRITE_COLLISION_FLAG], r_reg.fmt[FMT_TRF]} & r_reg.mask);
endmodule

/* File: verif/ssp_spi_port_monitor.sv */
`timescale 1ns/1ns
module ssp_spi_port_monitor (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       opt_pins_enable,
    input wire logic       sck_out,
    input wire logic       sck_oe,
    input wire logic       sdo_oe,
    input wire logic       slave_select_n_out,
    input wire logic       slave_select_n_oe,
    input wire logic       irq
);
    logic [4:0] edges_q;
    logic       sck_q;
    logic       wr_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // counts clock toggles inside one select frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edges_q <= 5'h00;
            sck_q   <= 1'b1;
            wr_q    <= 1'b0;
        end else begin
            edges_q <= slave_select_n_out ? 5'h00 : edges_q + {4'h0, sck_out != sck_q};
            sck_q   <= sck_out;
            wr_q    <= hsel & hready & htrans[1] & hwrite;
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    a_pins_float: assert property (!opt_pins_enable |-> !sck_oe && !sdo_oe && !slave_select_n_oe)
        else $error("pin driven while not assigned");
    a_eight_bits: assert property ($rose(slave_select_n_out) && $past(hresetn) |->
        edges_q + {4'h0, sck_out != sck_q} == 5'h10)
        else $error("frame without sixteen clock edges");
    a_half_period: assert property ($changed(sck_out) && !slave_select_n_out |=> $stable(sck_out))
        else $error("serial clock faster than a quarter");
    a_master_clock: assert property (!slave_select_n_out && slave_select_n_oe |-> sck_oe)
        else $error("select active without clock drive");
    a_duplex_oe: assert property (sck_oe |-> sdo_oe)
        else $error("clock driven without data out");
    a_irq_clear: assert property ($fell(irq) |-> wr_q || $past(wr_q) || $past(wr_q, 2))
        else $error("interrupt dropped without a write");
endmodule

/* File: verif/ssp_spi_slave_model.sv */
`timescale 1ns/1ns
module ssp_spi_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       ss_n,
    input  wire logic       cap_rise,
    input  wire logic       msb_first,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic      [7:0] rx_byte
);
    logic [7:0] sh;
    logic [3:0] n;
    initial miso = 1'b1;
    always @(negedge ss_n) begin
        sh = tx_byte;
        n = 4'h0;
        miso = msb_first ? sh[7] : sh[0];
    end
    // released line shows the inverse, so a stale bit cannot pass for data
    always @(posedge ss_n) miso = ~miso;
    // moves data only on the clock received from the master
    always @(sck) begin
        if (ss_n === 1'b0 && sck === cap_rise) begin
            rx_byte = msb_first ? {rx_byte[6:0], mosi} : {mosi, rx_byte[7:1]};
            n = n + 4'h1;
        end else if (ss_n === 1'b0 && n != 4'h0) begin
            sh = msb_first ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
            miso = msb_first ? sh[7] : sh[0];
        end
    end
endmodule

/* File: verif/ssp_spi_port_bench.sv */
`timescale 1ns/1ns
module ssp_spi_port_bench import ssp_pkg::*;;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, rd_samp;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, irq, sdi_in, sdo_out, sdo_oe, sck_out, sck_oe, sck_in, mosi;
    logic        slave_select_n_in, slave_select_n_out, slave_select_n_oe;
    logic        opt_pins_enable = 1, opt_select_pin_enable_enable = 1, opt_write_collision_flag_enable = 1;
    logic        sub_clk_tick = 0, timer_tone_output = 0, cap_rise = 1, msb_first = 0;
    logic [7:0]  tx_byte = 8'h00, rx_byte;
    int          err_count = 0, samples_checked = 0, cyc = 0;
    // pins carry pull-highs when nobody drives them
    assign sck_in = sck_oe ? sck_out : 1'b1;
    assign slave_select_n_in = slave_select_n_oe ? slave_select_n_out : 1'b1;
    assign mosi = sdo_oe ? sdo_out : 1'b1;
    assign hready = hreadyout;
    ssp_spi_port dut (.*);
    ssp_spi_slave_model peer (.sck(sck_in), .mosi(mosi), .ss_n(slave_select_n_in), .cap_rise(cap_rise),
        .msb_first(msb_first), .tx_byte(tx_byte), .miso(sdi_in), .rx_byte(rx_byte));
    always #4 hclk = ~hclk;
    always @(posedge hclk) rd_samp <= hrdata;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hready !== 1'b1);
        #1 rd = rd_samp;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            bus(1'b0, SSP_ADDR_STATUS, 8'h00);
            n++;
        end while (rd[0] !== 1'b1 && n < 200);
    endtask
    // f holds polarity, edge and order
    task automatic shot(input logic [2:0] f, input logic [7:0] mine, input logic [7:0] theirs);
        cap_rise  <= (f[2] == f[1]);
        msb_first <= f[0];
        tx_byte   <= theirs;
        bus(1'b1, SSP_ADDR_FORMAT, {2'b00, f, 3'b100});
        bus(1'b0, SSP_ADDR_FORMAT, 8'h00);
        chk(rd, {24'h0, 2'b00, f, 3'b100});
        chk({31'h0, sck_in}, {31'h0, ~f[2]});
        bus(1'b1, SSP_ADDR_DATA, mine);
        wait_done();
        chk({24'h0, rx_byte}, {24'h0, mine});
        bus(1'b0, SSP_ADDR_DATA, 8'h00);
        chk(rd, {24'h0, theirs});
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, SSP_ADDR_STATUS, 8'h03);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, SSP_ADDR_MODE, 8'h00);
        chk(rd, {24'h0, MODE_RESET});
        bus(1'b0, SSP_ADDR_FORMAT, 8'h00);
        chk(rd, {24'h0, FMT_RESET});
        bus(1'b0, 8'h14, 8'h00);
        chk(rd, 32'h0);
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, SSP_ADDR_MODE, {m[2:0], 5'b00001});
            bus(1'b0, SSP_ADDR_MODE, 8'h00);
            chk(rd, {24'h0, m[2:0], 5'b00000});
        end
        $display("register test done");
        bus(1'b1, SSP_ADDR_MODE, 8'h22);
        bus(1'b1, SSP_ADDR_MASK, 8'h03);
        for (int i = 0; i < 4; i++) begin
            shot({i[1], i[0], i[1] ^ i[0]}, 8'h3A ^ i[7:0], 8'hC6 ^ i[7:0]);
        end
        $display("transfer test done");
        bus(1'b1, SSP_ADDR_DATA, 8'h5B);
        bus(1'b1, SSP_ADDR_DATA, 8'hF0);
        wait_done();
        chk(rd & 32'h3, 32'h3);
        chk({24'h0, rx_byte}, 32'h5B);
        bus(1'b1, SSP_ADDR_STATUS, 8'h03);
        bus(1'b0, SSP_ADDR_STATUS, 8'h00);
        chk(rd, 32'h0);
        $display("collision test done");
        bus(1'b1, SSP_ADDR_FORMAT, 8'h00);
        repeat (2) @(posedge hclk);
        chk({31'h0, slave_select_n_oe}, 32'h0);
        bus(1'b1, SSP_ADDR_FORMAT, 8'h04);
        repeat (2) @(posedge hclk);
        chk({31'h0, slave_select_n_oe}, 32'h1);
        opt_pins_enable <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({31'h0, sck_oe}, 32'h0);
        opt_pins_enable <= 1'b1;
        bus(1'b1, SSP_ADDR_MODE, 8'h20);
        repeat (2) @(posedge hclk);
        chk({31'h0, sck_oe}, 32'h0);
        $display("pin test done");
        results();
    end
endmodule
bind ssp_spi_port ssp_spi_port_monitor mon (.*);
